// ===== src/tbtc_pkg.sv
// Package for the trace breakpoint trigger control block
package tbtc_pkg;

  // ---------------------------------------------------------------
  // Register selects within coprocessor register 23
  // ---------------------------------------------------------------
  localparam logic [2:0]  SEL_TRACE_BP_CTL = 3'h4;
  localparam logic [2:0]  SEL_CPLX_STATUS  = 3'h5;
  localparam logic [4:0]  REG_NUM_TRACE    = 5'h17;

  // ---------------------------------------------------------------
  // Field positions of the trace breakpoint control register
  // ---------------------------------------------------------------
  localparam int DATA_SEL_BIT   = 31;
  localparam int INSTR_SEL_BIT  = 15;
  localparam int DBP_EN_LSB     = 16;
  localparam int IBP_EN_LSB     = 0;
  localparam int NUM_IBP        = 6;
  localparam int NUM_DBP        = 2;

  // ---------------------------------------------------------------
  // Field positions of the complex breakpoint status register
  // ---------------------------------------------------------------
  localparam int STAT_RSVD_BIT  = 31;
  localparam int STAT_PRM_BIT   = 3;
  localparam int STAT_DQ_BIT    = 2;
  localparam int STAT_TUP_BIT   = 1;
  localparam int STAT_PASS_COUNTER_SEEN_BIT  = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] TRACE_BP_CTL_RST = 32'h0000_0000;
  localparam logic [3:0]  CPLX_STATUS_RST  = 4'h0;

  // Complex breakpoint conditions seen at a debug exception
  typedef struct packed {
    logic primed;
    logic data_qual;
    logic tuple_bp;
    logic pass_cnt;
  } tbtc_cplx_s;

  // Coprocessor register move request
  typedef struct packed {
    logic        wr;
    logic [4:0]  regnum;
    logic [2:0]  sel;
    logic [31:0] wdata;
  } tbtc_cop_req_s;

endpackage : tbtc_pkg

// ===== src/tbtc_trigger_gate.sv
// Trigger gating: breakpoint hits to one trace start request
`timescale 1ns/1ns
`default_nettype none

module tbtc_trigger_gate #(
  parameter int NUM_IBP = 6,
  parameter int NUM_DBP = 2
) (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic [NUM_IBP-1:0] ibp_hit_i,
  input  wire logic [NUM_DBP-1:0] dbp_hit_i,
  input  wire logic [NUM_IBP-1:0] ibp_en_i,
  input  wire logic [NUM_DBP-1:0] dbp_en_i,
  input  wire logic               instr_sel_i,
  input  wire logic               data_sel_i,
  input  wire logic               trace_on_i,
  output logic                    trace_start_o
);

  logic [NUM_IBP-1:0] ibp_pass;
  logic [NUM_DBP-1:0] dbp_pass;
  logic               next_trace_start;
  logic               trace_start;

  // ---------------------------------------------------------------
  // Per-breakpoint qualification
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_IBP; g++) begin : g_ibp
      // Hit, class enable and own enable all needed
      assign ibp_pass[g] = ibp_hit_i[g] & instr_sel_i & ibp_en_i[g];
    end
    for (g = 0; g < NUM_DBP; g++) begin : g_dbp
      assign dbp_pass[g] = dbp_hit_i[g] & data_sel_i & dbp_en_i[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Start request
  // ---------------------------------------------------------------
  // Hits are only observed, never consumed, so the same breakpoint
  // may still raise its debug exception in parallel
  always_comb begin
    next_trace_start = trace_on_i & (|{ibp_pass, dbp_pass});
  end

  // Registered so the start pulse is glitch free
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trace_start <= 1'b0;
    end else begin
      trace_start <= next_trace_start;
    end
  end

  assign trace_start_o = trace_start;

endmodule : tbtc_trigger_gate

`default_nettype wire

// ===== src/tbtc_top.sv
// Trace breakpoint control and complex breakpoint status registers
`timescale 1ns/1ns
`default_nettype none

module tbtc_top #(
  parameter bit CPLX_BP_PRESENT = 1'b1,
  parameter int NUM_IBP         = tbtc_pkg::NUM_IBP,
  parameter int NUM_DBP         = tbtc_pkg::NUM_DBP
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // Coprocessor move interface
  input  wire tbtc_pkg::tbtc_cop_req_s cop_req_i,
  input  wire logic                  cop_valid_i,
  output logic [31:0]                cop_rdata_o,
  output logic                       cop_hit_o,
  // Breakpoint side
  input  wire logic [NUM_IBP-1:0]    ibp_hit_i,
  input  wire logic [NUM_DBP-1:0]    dbp_hit_i,
  input  wire logic                  debug_exc_i,
  input  wire tbtc_pkg::tbtc_cplx_s  cplx_seen_i,
  // Trace controller side
  input  wire logic                  trace_on_i,
  output logic                       trace_start_o
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic sel_match(input tbtc_pkg::tbtc_cop_req_s r,
                                     input logic [2:0] s);
    sel_match = (r.regnum == tbtc_pkg::REG_NUM_TRACE) && (r.sel == s);
  endfunction : sel_match

  logic acc_ctl;
  logic acc_stat;

  assign acc_ctl  = cop_valid_i & sel_match(cop_req_i, tbtc_pkg::SEL_TRACE_BP_CTL);
  assign acc_stat = cop_valid_i & CPLX_BP_PRESENT
                  & sel_match(cop_req_i, tbtc_pkg::SEL_CPLX_STATUS);
  assign cop_hit_o = acc_ctl | acc_stat;

  // ---------------------------------------------------------------
  // Trace breakpoint control fields
  // ---------------------------------------------------------------
  // Only the implemented bits are flops; the gap reads as zero
  logic               data_sel;
  logic               instr_sel;
  logic [NUM_IBP-1:0] ibp_en;
  logic [NUM_DBP-1:0] dbp_en;
  logic               next_data_sel;
  logic               next_instr_sel;
  logic [NUM_IBP-1:0] next_ibp_en;
  logic [NUM_DBP-1:0] next_dbp_en;

  // Write path
  always_comb begin
    next_data_sel  = data_sel;
    next_instr_sel = instr_sel;
    next_ibp_en    = ibp_en;
    next_dbp_en    = dbp_en;
    if (acc_ctl && cop_req_i.wr) begin
      next_data_sel  = cop_req_i.wdata[tbtc_pkg::DATA_SEL_BIT];
      next_instr_sel = cop_req_i.wdata[tbtc_pkg::INSTR_SEL_BIT];
      next_ibp_en    = cop_req_i.wdata[tbtc_pkg::IBP_EN_LSB +: NUM_IBP];
      next_dbp_en    = cop_req_i.wdata[tbtc_pkg::DBP_EN_LSB +: NUM_DBP];
    end
  end

  // Control bits clear at reset so nothing triggers until enabled
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_sel  <= tbtc_pkg::TRACE_BP_CTL_RST[tbtc_pkg::DATA_SEL_BIT];
      instr_sel <= tbtc_pkg::TRACE_BP_CTL_RST[tbtc_pkg::INSTR_SEL_BIT];
      ibp_en    <= tbtc_pkg::TRACE_BP_CTL_RST[tbtc_pkg::IBP_EN_LSB +: NUM_IBP];
      dbp_en    <= tbtc_pkg::TRACE_BP_CTL_RST[tbtc_pkg::DBP_EN_LSB +: NUM_DBP];
    end else begin
      data_sel  <= next_data_sel;
      instr_sel <= next_instr_sel;
      ibp_en    <= next_ibp_en;
      dbp_en    <= next_dbp_en;
    end
  end

  // ---------------------------------------------------------------
  // Complex breakpoint status capture
  // ---------------------------------------------------------------
  // Read-only to software; loaded only by the debug exception
  tbtc_pkg::tbtc_cplx_s cplx_stat;
  tbtc_pkg::tbtc_cplx_s next_cplx_stat;

  always_comb begin
    next_cplx_stat = cplx_stat;
    if (debug_exc_i && CPLX_BP_PRESENT) begin
      next_cplx_stat.primed    = cplx_seen_i.primed;
      next_cplx_stat.data_qual = cplx_seen_i.data_qual;
      next_cplx_stat.tuple_bp  = cplx_seen_i.tuple_bp;
      next_cplx_stat.pass_cnt  = cplx_seen_i.pass_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cplx_stat <= tbtc_pkg::CPLX_STATUS_RST;
    end else begin
      cplx_stat <= next_cplx_stat;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [31:0] rdata;

  // Registered read: data appears the cycle after the move
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc_ctl) begin
      next_rdata[tbtc_pkg::DATA_SEL_BIT]  = data_sel;
      next_rdata[tbtc_pkg::INSTR_SEL_BIT] = instr_sel;
      next_rdata[tbtc_pkg::IBP_EN_LSB +: NUM_IBP] = ibp_en;
      next_rdata[tbtc_pkg::DBP_EN_LSB +: NUM_DBP] = dbp_en;
    end else if (acc_stat) begin
      next_rdata[tbtc_pkg::STAT_RSVD_BIT] = 1'b1;
      next_rdata[tbtc_pkg::STAT_PRM_BIT]  = cplx_stat.primed;
      next_rdata[tbtc_pkg::STAT_DQ_BIT]   = cplx_stat.data_qual;
      next_rdata[tbtc_pkg::STAT_TUP_BIT]  = cplx_stat.tuple_bp;
      next_rdata[tbtc_pkg::STAT_PASS_COUNTER_SEEN_BIT] = cplx_stat.pass_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign cop_rdata_o = rdata;

  // ---------------------------------------------------------------
  // Trigger gating
  // ---------------------------------------------------------------
  tbtc_trigger_gate #(
    .NUM_IBP (NUM_IBP),
    .NUM_DBP (NUM_DBP)
  ) u_gate (
    .clk_i         (clk_i),
    .srst_i        (srst_i),
    .ibp_hit_i     (ibp_hit_i),
    .dbp_hit_i     (dbp_hit_i),
    .ibp_en_i      (ibp_en),
    .dbp_en_i      (dbp_en),
    .instr_sel_i   (instr_sel),
    .data_sel_i    (data_sel),
    .trace_on_i    (trace_on_i),
    .trace_start_o (trace_start_o)
  );

endmodule : tbtc_top

`default_nettype wire

// ===== verif/tbtc_assertions.sv
// Port-level checker for the trace breakpoint trigger control block
`timescale 1ns/1ns
`default_nettype none
module tbtc_assertions #(
  parameter int NUM_IBP = 6,
  parameter int NUM_DBP = 2
) (
  input wire logic                    clk_i,
  input wire logic                    srst_i,
  input wire tbtc_pkg::tbtc_cop_req_s cop_req_i,
  input wire logic                    cop_valid_i,
  input wire logic [31:0]             cop_rdata_o,
  input wire logic                    cop_hit_o,
  input wire logic [NUM_IBP-1:0]      ibp_hit_i,
  input wire logic [NUM_DBP-1:0]      dbp_hit_i,
  input wire logic                    debug_exc_i,
  input wire tbtc_pkg::tbtc_cplx_s    cplx_seen_i,
  input wire logic                    trace_on_i,
  input wire logic                    trace_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----------
  // Access steps
  // ----------
  sequence acc_s(logic w, logic [2:0] s);
    cop_valid_i && cop_req_i.wr == w && cop_req_i.regnum == 5'h17
      && cop_req_i.sel == s;
  endsequence
  sequence exc_rd_s;
    debug_exc_i ##1 (!debug_exc_i ##0 acc_s(1'b0, 3'h5));
  endsequence
  // Read-back holds only the implemented control fields
  ctl_loop_a: assert property (acc_s(1'b1, 3'h4) ##1 acc_s(1'b0, 3'h4)
    |=> cop_rdata_o == ($past(cop_req_i.wdata, 2) & 32'h8003_803f))
    else $error("control read-back wrong");
  ctl_rsvd_a: assert property (acc_s(1'b0, 3'h4) |=> cop_rdata_o[14:6] == 9'h0)
    else $error("control gap bits not zero");
  stat_one_a: assert property (acc_s(1'b0, 3'h5) |=> cop_rdata_o[31])
    else $error("status top bit not one");
  stat_zero_a: assert property (acc_s(1'b0, 3'h5) |=> cop_rdata_o[30:4] == 27'h0)
    else $error("status middle bits not zero");
  stat_cap_a: assert property (exc_rd_s
    |=> cop_rdata_o[3:0] == $past(cplx_seen_i, 2))
    else $error("status flags not captured");
  stat_map_a: assert property (acc_s(1'b0, 3'h5) |-> cop_hit_o)
    else $error("status register not decoded");
  ctl_map_a: assert property (acc_s(1'b1, 3'h4) |-> cop_hit_o)
    else $error("control register not decoded");
  miss_map_a: assert property (cop_valid_i && cop_req_i.sel > 3'h5
    |-> !cop_hit_o ##1 cop_rdata_o == 32'h0) else $error("unmapped access answered");
  trace_off_a: assert property (!trace_on_i |=> !trace_start_o)
    else $error("start while tracing off");
  no_hit_a: assert property (ibp_hit_i == '0 && dbp_hit_i == '0 |=> !trace_start_o)
    else $error("start without any hit");
endmodule : tbtc_assertions

bind tbtc_top tbtc_assertions #(.NUM_IBP(NUM_IBP), .NUM_DBP(NUM_DBP))
  i_tbtc_assertions (.clk_i(clk_i), .srst_i(srst_i), .cop_req_i(cop_req_i),
  .cop_valid_i(cop_valid_i), .cop_rdata_o(cop_rdata_o), .cop_hit_o(cop_hit_o),
  .ibp_hit_i(ibp_hit_i), .dbp_hit_i(dbp_hit_i), .debug_exc_i(debug_exc_i),
  .cplx_seen_i(cplx_seen_i), .trace_on_i(trace_on_i),
  .trace_start_o(trace_start_o));
`default_nettype wire

// ===== verif/tbtc_bp_model.sv
// Breakpoint side model: debug exception pulses with condition flags
`timescale 1ns/1ns
`default_nettype none
module tbtc_bp_model (
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  input  wire logic            exc_req_i,
  input  wire tbtc_pkg::tbtc_cplx_s cond_i,
  output logic                 debug_exc_o,
  output tbtc_pkg::tbtc_cplx_s cplx_seen_o
);
  // One-cycle pulse; flags churn outside it so late sampling shows
  always @(posedge clk_i) begin
    if (srst_i) begin
      debug_exc_o <= 1'b0;
      cplx_seen_o <= '0;
    end else begin
      debug_exc_o <= exc_req_i;
      cplx_seen_o <= exc_req_i ? cond_i : ~cplx_seen_o;
    end
  end
endmodule : tbtc_bp_model
`default_nettype wire

// ===== verif/tbtc_top_tb.sv
// Self-checking bench for the trace breakpoint trigger control block
`timescale 1ns/1ns
`default_nettype none
module tbtc_top_tb;
  // ----------
  // Stimulus and scoreboard state
  // ----------
  logic clk = 1'b0, srst = 1'b1, vld = 1'b0, exc_req = 1'b0;
  logic chk = 1'b0, chk_d = 1'b0, on = 1'b0, hit, exc, start;
  logic [5:0] ibp = '0;
  logic [1:0] dbp = '0;
  logic [31:0] rdata, got;
  logic [32:0] e;
  logic [32:0] q[$];
  tbtc_pkg::tbtc_cop_req_s req = '0;
  tbtc_pkg::tbtc_cplx_s cond = '0, seen;
  int mismatches = 0, tests_run = 0;

  always #4 clk = ~clk;

  tbtc_top i_tbtc_top (.clk_i(clk), .srst_i(srst), .cop_req_i(req),
    .cop_valid_i(vld), .cop_rdata_o(rdata), .cop_hit_o(hit),
    .ibp_hit_i(ibp), .dbp_hit_i(dbp), .debug_exc_i(exc),
    .cplx_seen_i(seen), .trace_on_i(on), .trace_start_o(start));
  tbtc_bp_model i_tbtc_bp_model (.clk_i(clk), .srst_i(srst),
    .exc_req_i(exc_req), .cond_i(cond), .debug_exc_o(exc),
    .cplx_seen_o(seen));

  // ----------
  // Drivers: kind bit 32 of a note marks a start check
  // ----------
  task automatic drv(input logic v, w, input logic [2:0] s,
      input logic [31:0] d, input logic [8:0] h, input logic c,
      input logic [32:0] n);
    @(posedge clk);
    vld <= v;
    req <= {w, 5'h17, s, d};
    {on, dbp, ibp} <= h;
    chk <= c;
    if (c) q.push_back(n);
  endtask : drv
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    drv(1'b1, 1'b1, s, d, 9'h0, 1'b0, '0);
  endtask : wr
  task automatic rd(input logic [2:0] s, input logic [31:0] x);
    drv(1'b1, 1'b0, s, 32'h0, 9'h0, 1'b1, {1'b0, x});
  endtask : rd
  task automatic trig(input logic [8:0] h, input logic x);
    drv(1'b0, 1'b0, 3'h4, 32'h0, h, 1'b1, {1'b1, 31'h0, x});
  endtask : trig
  // Exception and a live trigger from one breakpoint at once
  task automatic exc_c(input logic [3:0] c);
    drv(1'b0, 1'b0, 3'h4, 32'h0, 9'h101, 1'b1, {1'b1, 31'h0, 1'b1});
    exc_req <= 1'b1;
    cond <= c;
    @(posedge clk);
    exc_req <= 1'b0;
    chk <= 1'b0;
  endtask : exc_c
  task automatic rst;
    @(posedge clk);
    srst <= 1'b1;
    vld <= 1'b0;
    chk <= 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask : rst
  function automatic logic fx(input logic [31:0] d, input logic [8:0] h);
    return h[8] & (|(h[5:0] & d[5:0] & {6{d[15]}})
      | |(h[7:6] & d[17:16] & {2{d[31]}}));
  endfunction : fx
  task automatic wrap_up;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ----------
  // Monitor: oldest note against the settled outputs
  // ----------
  always @(posedge clk) chk_d <= chk;
  always @(negedge clk) begin
    if (chk_d) begin
      e = q.pop_front();
      got = e[32] ? {31'h0, start} : rdata;
      tests_run++;
      if (got !== e[31:0]) begin
        mismatches++;
        $display("[ERR] %0t got %h expected %h", $time, got, e[31:0]);
      end
    end
  end

  // Hang guard, far beyond the 185 cycles of the sequence
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    logic [8:0] h;
    void'($urandom(32'habce3b75));
    rst();
    rd(3'h4, 32'h0);
    rd(3'h5, 32'h8000_0000);
    for (int n = 0; n < 8; n++) begin
      d = (n < 6) ? (32'h8000 | (32'h1 << n)) : (32'h8000_0000 | (32'h1 << (n + 10)));
      h = 9'h100 | (9'h1 << n);
      wr(3'h4, d);
      trig(h, 1'b1);
      wr(3'h4, d & 32'h0003_003f);
      trig(h, 1'b0);
      wr(3'h4, d);
      trig(h & 9'h0ff, 1'b0);
    end
    repeat (24) begin
      d = $urandom;
      h = 9'($urandom);
      wr(3'h4, d);
      rd(3'h4, d & 32'h8003_803f);
      trig(h, fx(d, h));
    end
    wr(3'h4, 32'h8001);
    for (int k = 0; k < 16; k++) begin
      exc_c(4'(k));
      rd(3'h5, 32'h8000_0000 | k);
    end
    wr(3'h5, 32'hffff_ffff);
    rd(3'h5, 32'h8000_000f);
    rd(3'h6, 32'h0);
    rd(3'h3, 32'h0);
    rst();
    rd(3'h4, 32'h0);
    @(posedge clk);
    vld <= 1'b0;
    chk <= 1'b0;
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : tbtc_top_tb
`default_nettype wire
